// [src/burst_pkg.sv]
package burst_pkg;

  // ---------------------------------------------------------------
  // burst setup field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] SETUP_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] SETUP_PER_COMMAND = 2'h1;
  localparam logic [1:0] SETUP_FIXED_CHOP  = 2'h2;

  // ---------------------------------------------------------------
  // burst and pipeline sizes
  // ---------------------------------------------------------------
  localparam int         DATA_W       = 16;  // two x8 beats per clock
  localparam int         FIFO_DEPTH   = 8;
  localparam int         LINE_DEPTH   = 80;
  localparam int         DELAY_W      = 7;
  localparam logic [2:0] CLKS_EIGHT   = 3'h4;  // eight beats, double rate
  localparam logic [2:0] CLKS_CHOP    = 3'h2;  // four beats, double rate
  localparam logic [4:0] WR_CAS_LOWEST = 5'h09;
  localparam logic [DELAY_W-1:0] DELAY_MIN = 7'h02;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic sel;  // burst_select_address_bit
  } cmd_t;

  typedef struct packed {
    logic [1:0] setup;    // burst_setup_register field
    logic [4:0] rd_cas;   // read_cas_latency_setting
    logic [4:0] add_lat;  // additive_latency_setting
    logic [2:0] par_lat;  // parity_delay
    logic [4:0] wr_cas;   // write_cas_latency_setting
    logic       rd_pre2;
    logic       wr_pre2;
  } cfg_t;

  typedef struct packed {
    logic start;
    logic rd;
    logic chop;
    logic pre2;
  } slot_t;

endpackage

// [src/burst_sel.sv]
// Overview of operation
// RL1: with setup 00, or 01 and the select bit high, a read or write moves eight beats.
// RL2: with setup 01 and the select bit low, that command moves a four-beat chop.
// RL3: with setup 10 every read and write is a four-beat chop whatever the select bit.
// RL4: in two-clock write preamble mode the controller sets write CAS at least one above the lowest.
// RL5: in per-command mode each command keeps its own burst length, mixed freely.
// RL6: read data starts CAS latency plus additive plus parity latency after the command.
// RL7: the strobe carries a one- or two-clock preamble right before each first beat.
`timescale 1ns/1ps
`default_nettype none

module burst_fifo
  import burst_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage has no reset, only valid words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end
endmodule

module burst_sel
  import burst_pkg::*;
(
  // clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              ARST_N,
  // command pins from the controller
  input  wire logic              CMD_RD,
  input  wire logic              CMD_WR,
  input  wire logic              BURST_SELECT_ADDRESS_BIT,
  // mode pins
  input  wire logic [1:0]        BURST_SETUP,
  input  wire logic [4:0]        READ_CAS_LATENCY,
  input  wire logic [4:0]        ADDITIVE_LATENCY,
  input  wire logic [2:0]        PARITY_DELAY,
  input  wire logic [4:0]        WRITE_CAS_LATENCY,
  input  wire logic              READ_PREAMBLE_2CLK,
  input  wire logic              WRITE_PREAMBLE_2CLK,
  // read data from the array
  input  wire logic              RD_DATA_VALID,
  input  wire logic [DATA_W-1:0] RD_DATA,
  output logic                   RD_DATA_READY,
  // data and strobe pins
  output logic [DATA_W-1:0]      DQ_OUT,
  output logic                   DQ_OE,
  output logic                   DQS_OE,
  output logic                   DQS_PREAMBLE,
  // status
  output logic                   READ_BEAT,
  output logic                   WRITE_BEAT,
  output logic                   BURST_CHOPPED,
  output logic                   DATA_UNDERRUN,
  output logic                   WR_CAS_TOO_LOW
);

  typedef struct packed {
    cmd_t                        cmd_m;
    cmd_t                        cmd_s;
    cfg_t                        cfg_m;
    cfg_t                        cfg_s;
    slot_t [LINE_DEPTH-1:0]      line;
    logic  [2:0]                 cnt;
    logic                        rd;
    logic                        chop;
    logic  [DATA_W-1:0]          dq;
    logic                        dq_oe;
    logic                        dqs_oe;
    logic                        pre;
    logic                        rd_beat;
    logic                        wr_beat;
    logic                        underrun;
    logic                        cwl_err;
  } state_t;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_chop(input logic [1:0] setup,
                                   input logic       sel);
    is_chop = (setup == SETUP_FIXED_CHOP) |               // RL3
              ((setup == SETUP_PER_COMMAND) & ~sel);      // RL2
  endfunction

  function automatic logic [DELAY_W-1:0] delay_of(input cfg_t c,
                                                  input logic rd);
    logic [DELAY_W-1:0] cas;
    cas = rd ? DELAY_W'(c.rd_cas) : DELAY_W'(c.wr_cas);
    delay_of = cas + DELAY_W'(c.add_lat) + DELAY_W'(c.par_lat);
  endfunction

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_m_reg;
  logic rst_n;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_m_reg <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_m_reg <= 1'b1;
      rst_n     <= rst_m_reg;
    end
  end

  // ---------------------------------------------------------------
  // read data buffer
  // ---------------------------------------------------------------
  state_t             s_reg;
  state_t             s_next;
  logic               fifo_valid;
  logic [DATA_W-1:0]  fifo_data;
  logic               fifo_pop;
  logic               fifo_in_ready;

  burst_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK_SYS),
    .rst_n     (rst_n),
    .in_valid  (RD_DATA_VALID),
    .in_data   (RD_DATA),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  // ---------------------------------------------------------------
  // command scheduling and burst engine
  // ---------------------------------------------------------------
  logic               take;
  logic               take_rd;
  logic [DELAY_W-1:0] dsum;
  slot_t              head;
  logic               beat_rd;

  assign take    = s_reg.cmd_s.rd | s_reg.cmd_s.wr;
  assign take_rd = s_reg.cmd_s.rd;  // read wins if both arrive
  assign dsum    = delay_of(s_reg.cfg_s, take_rd);
  assign head    = s_reg.line[0];
  // a word leaves the buffer one clock ahead of each read beat
  assign beat_rd = head.start ? head.rd : (s_reg.cnt > 3'h1) & s_reg.rd;
  assign fifo_pop = beat_rd & fifo_valid & (head.start | (s_reg.cnt > 3'h1));

  always_comb begin
    s_next       = s_reg;
    s_next.cmd_m = '{rd: CMD_RD, wr: CMD_WR, sel: BURST_SELECT_ADDRESS_BIT};
    s_next.cmd_s = s_reg.cmd_m;
    s_next.cfg_m = '{setup: BURST_SETUP, rd_cas: READ_CAS_LATENCY,
                     add_lat: ADDITIVE_LATENCY, par_lat: PARITY_DELAY,
                     wr_cas: WRITE_CAS_LATENCY, rd_pre2: READ_PREAMBLE_2CLK,
                     wr_pre2: WRITE_PREAMBLE_2CLK};
    s_next.cfg_s = s_reg.cfg_m;

    for (int i = 0; i < LINE_DEPTH - 1; i++) begin
      s_next.line[i] = s_reg.line[i+1];
    end
    s_next.line[LINE_DEPTH-1] = '0;
    // slot at delay-1 reaches the head one clock before the first beat
    if (take && dsum >= DELAY_MIN) begin
      s_next.line[dsum - 1'b1] = '{start: 1'b1, rd: take_rd,          // RL6
        chop: is_chop(s_reg.cfg_s.setup, s_reg.cmd_s.sel),            // RL5
        pre2: take_rd ? s_reg.cfg_s.rd_pre2 : s_reg.cfg_s.wr_pre2};
    end

    if (head.start) begin
      s_next.cnt  = head.chop ? CLKS_CHOP : CLKS_EIGHT;               // RL1
      s_next.rd   = head.rd;
      s_next.chop = head.chop;
    end else if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end

    // strobe preamble one or two clocks ahead of the first beat
    s_next.pre = s_reg.line[1].start |
                 (s_reg.line[2].start & s_reg.line[2].pre2);          // RL7
    s_next.rd_beat = s_next.cnt != '0 && s_next.rd;
    s_next.wr_beat = s_next.cnt != '0 && !s_next.rd;
    s_next.dq_oe   = s_next.rd_beat;
    s_next.dqs_oe  = s_next.rd_beat |
                     (s_next.pre & (s_reg.line[1].start ? s_reg.line[1].rd
                                                       : s_reg.line[2].rd));
    s_next.dq = fifo_pop ? fifo_data : '0;
    if (beat_rd && !fifo_valid && (head.start || s_reg.cnt > 3'h1)) begin
      s_next.underrun = 1'b1;
    end
    // flags a controller setting that breaks the two-clock write mode
    s_next.cwl_err = s_reg.cfg_s.wr_pre2 &&
                     s_reg.cfg_s.wr_cas <= WR_CAS_LOWEST;             // RL4
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      s_reg         <= '0;
      RD_DATA_READY <= 1'b0;
    end else begin
      s_reg         <= s_next;
      RD_DATA_READY <= fifo_in_ready;
    end
  end

  assign DQ_OUT         = s_reg.dq;
  assign DQ_OE          = s_reg.dq_oe;
  assign DQS_OE         = s_reg.dqs_oe;
  assign DQS_PREAMBLE   = s_reg.pre;
  assign READ_BEAT      = s_reg.rd_beat;
  assign WRITE_BEAT     = s_reg.wr_beat;
  assign BURST_CHOPPED  = s_reg.chop;
  assign DATA_UNDERRUN  = s_reg.underrun;
  assign WR_CAS_TOO_LOW = s_reg.cwl_err;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence seq_eight;
    (READ_BEAT | WRITE_BEAT) [*4];
  endsequence
  sequence seq_chop;
    (READ_BEAT | WRITE_BEAT) [*2];
  endsequence

  eight_beat_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RL1
    head.start && !head.chop |=> seq_eight)
    else $error("eight-beat burst too short");
  chop_beat_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RL2
    head.start && head.chop && !s_reg.line[1].start && !s_reg.line[2].start
    |=> seq_chop ##1 !(READ_BEAT | WRITE_BEAT))
    else $error("chopped burst not two clocks");
  fixed_chop_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RL3
    take && dsum >= DELAY_MIN && s_reg.cfg_s.setup == SETUP_FIXED_CHOP
    |=> s_reg.line[$past(dsum) - 1'b1].chop)
    else $error("fixed chop mode gave eight beats");
  per_cmd_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RL5
    take && dsum >= DELAY_MIN && s_reg.cfg_s.setup == SETUP_PER_COMMAND
    |=> s_reg.line[$past(dsum) - 1'b1].chop == !$past(s_reg.cmd_s.sel))
    else $error("per-command length not applied");
  rd_delay_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RL6
    take_rd && dsum >= DELAY_MIN
    |=> s_reg.line[$past(dsum) - 1'b1].start &&
        s_reg.line[$past(dsum) - 1'b1].rd)
    else $error("read not placed at its latency");
  preamble_one_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RL7
    head.start |-> DQS_PREAMBLE)
    else $error("strobe preamble missing");
  preamble_two_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RL7
    head.start && head.pre2 && $past(s_reg.cnt) == 3'h0
    |-> $past(DQS_PREAMBLE))
    else $error("two-clock preamble missing");
  cwl_check_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // RL4
    s_reg.cfg_s.wr_pre2 && s_reg.cfg_s.wr_cas <= WR_CAS_LOWEST
    |=> WR_CAS_TOO_LOW)
    else $error("low write CAS not flagged");
endmodule
`default_nettype wire

// [verification/ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
  import burst_pkg::*;
(
  // clock
  input  wire logic              clk,
  // command pins
  output logic                   cmd_rd,
  output logic                   cmd_wr,
  output logic                   sel,
  // array read feed
  input  wire logic              rd_ready,
  output logic                   rd_valid,
  output logic      [DATA_W-1:0] rd_data
);
  logic       feed_en;
  logic [1:0] phase;
  logic [7:0] n;

  initial begin
    cmd_rd   = 1'b0;
    cmd_wr   = 1'b0;
    sel      = 1'b0;
    rd_valid = 1'b0;
    rd_data  = 16'h0000;
    feed_en  = 1'b1;
    phase    = 2'h0;
    n        = 8'h00;
  end

  // --------------------------------------------------------------
  // array feed and command pulses
  // --------------------------------------------------------------
  // one word every fourth clock: the ready seen here is two clocks stale,
  // so a slower pace keeps a word from landing on a full buffer
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    if (feed_en && rd_ready && phase == 2'h0) begin
      rd_valid <= 1'b1;
      rd_data  <= {8'h01, n};
      n        <= n + 8'h01;
    end else begin
      rd_valid <= 1'b0;
      rd_data  <= ~rd_data;
    end
  end

  task automatic issue(input logic rd, input logic wr, input logic s);
    @(posedge clk);
    cmd_rd <= rd;
    cmd_wr <= wr;
    sel    <= s;
    @(posedge clk);
    cmd_rd <= 1'b0;
    cmd_wr <= 1'b0;
    sel    <= ~s;
  endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
  import burst_pkg::*;
;
  logic              clk_sys, arst_n;
  cfg_t              cfg;
  logic              cmd_rd, cmd_wr, sel, rd_valid, rd_ready;
  logic [DATA_W-1:0] rd_data, dq_out;
  logic              dq_oe, dqs_oe, dqs_pre, rd_beat, wr_beat;
  logic              chopped, underrun, cas_low;
  logic [7:0]        idx = 8'h00;
  int                miscompares = 0;
  int                cmp_count = 0;

  burst_sel burst_sel_i (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .CMD_RD(cmd_rd),
    .CMD_WR(cmd_wr), .BURST_SELECT_ADDRESS_BIT(sel),
    .BURST_SETUP(cfg.setup), .READ_CAS_LATENCY(cfg.rd_cas),
    .ADDITIVE_LATENCY(cfg.add_lat), .PARITY_DELAY(cfg.par_lat),
    .WRITE_CAS_LATENCY(cfg.wr_cas), .READ_PREAMBLE_2CLK(cfg.rd_pre2),
    .WRITE_PREAMBLE_2CLK(cfg.wr_pre2), .RD_DATA_VALID(rd_valid),
    .RD_DATA(rd_data), .RD_DATA_READY(rd_ready), .DQ_OUT(dq_out),
    .DQ_OE(dq_oe), .DQS_OE(dqs_oe), .DQS_PREAMBLE(dqs_pre),
    .READ_BEAT(rd_beat), .WRITE_BEAT(wr_beat), .BURST_CHOPPED(chopped),
    .DATA_UNDERRUN(underrun), .WR_CAS_TOO_LOW(cas_low));

  ctrl_model ctrl_model_i (
    .clk(clk_sys), .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .sel(sel),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data));

  // --------------------------------------------------------------
  // checking helpers
  // --------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // cycle k is the one after edge k, counted from the command pin
  // first beat: delay sum, two synchroniser clocks, one slot load
  task automatic watch(input logic rd, input int k0, input int first,
                       input int len, input logic pre2, input logic dat);
    int   f;
    int   cnt;
    logic p1;
    logic p2;
    logic b;
    logic done;
    logic q1;
    f = -1;
    cnt = 0;
    p1 = 1'b0;
    p2 = 1'b0;
    done = 1'b0;
    q1 = 1'b0;
    for (int k = k0; k < k0 + 60 && !done; k++) begin
      @(posedge clk_sys);
      #1;
      b = rd ? rd_beat : wr_beat;
      if (b === 1'b1) begin
        if (f < 0) begin
          f = k;
          chk("first beat", 16'(first), 16'(k));
          chk("preamble", 16'h1, 16'(p1));
          chk("early preamble", 16'(pre2), 16'(p2));
          chk("preamble enable", 16'(rd), 16'(q1));
        end
        cnt++;
        chk("strobe enable", 16'(rd), 16'(dqs_oe));
        if (rd && dat) begin
          chk("read word", {8'h01, idx}, dq_out);
          chk("data enable", 16'h1, 16'(dq_oe));
          idx++;
        end
      end else if (f >= 0) begin
        done = 1'b1;
      end
      p2 = p1;
      p1 = dqs_pre;
      q1 = dqs_oe;
    end
    if (!done) begin
      miscompares++;
      $display("[FAIL] burst end expected within bound seen none");
      tally_and_finish();
    end
    chk("beat count", 16'(len), 16'(cnt));
    chk("chop flag", 16'(len != 4), 16'(chopped));
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_modes();
    logic [1:0] st [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
    logic       sl [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    int         ln [7] = '{4, 4, 2, 2, 2, 4, 4};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      cfg.setup <= st[i];
      repeat (4) @(posedge clk_sys);
      ctrl_model_i.issue(1'b1, 1'b0, sl[i]);
      watch(1'b1, 2, 14, ln[i], 1'b0, 1'b1);
    end
    $display("test modes done");
  endtask

  task automatic t_mixed();
    @(posedge clk_sys);
    cfg.setup <= SETUP_PER_COMMAND;
    repeat (4) @(posedge clk_sys);
    ctrl_model_i.issue(1'b1, 1'b0, 1'b1);
    repeat (2) @(posedge clk_sys);
    ctrl_model_i.issue(1'b1, 1'b0, 1'b0);
    watch(1'b1, 6, 14, 6, 1'b0, 1'b1);
    $display("test mixed done");
  endtask

  task automatic t_pre();
    @(posedge clk_sys);
    cfg.rd_pre2 <= 1'b1;
    cfg.wr_pre2 <= 1'b1;
    cfg.wr_cas <= 5'h0a;
    cfg.add_lat <= 5'h02;
    cfg.par_lat <= 3'h4;
    repeat (4) @(posedge clk_sys);
    ctrl_model_i.issue(1'b1, 1'b0, 1'b1);
    watch(1'b1, 2, 20, 4, 1'b1, 1'b1);
    ctrl_model_i.issue(1'b0, 1'b1, 1'b0);
    watch(1'b0, 2, 19, 2, 1'b1, 1'b0);
    chk("cas flag", 16'h0, 16'(cas_low));
    @(posedge clk_sys);
    cfg.wr_cas <= WR_CAS_LOWEST;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("cas flag", 16'h1, 16'(cas_low));
    @(posedge clk_sys);
    cfg <= '{SETUP_PER_COMMAND, 5'h0b, 5'h00, 3'h0, 5'h0a, 1'b0, 1'b0};
    $display("test preamble done");
  endtask

  task automatic t_under();
    repeat (30) @(posedge clk_sys);
    #1;
    chk("fifo ready", 16'h0, 16'(rd_ready));
    ctrl_model_i.feed_en = 1'b0;
    repeat (2) begin
      ctrl_model_i.issue(1'b1, 1'b0, 1'b1);
      watch(1'b1, 2, 14, 4, 1'b0, 1'b1);
    end
    chk("underrun", 16'h0, 16'(underrun));
    chk("fifo ready", 16'h1, 16'(rd_ready));
    ctrl_model_i.issue(1'b1, 1'b0, 1'b1);
    watch(1'b1, 2, 14, 4, 1'b0, 1'b0);
    chk("underrun", 16'h1, 16'(underrun));
    // only a reset clears the sticky underrun
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("underrun in reset", 16'h0, 16'(underrun));
    chk("fifo ready in reset", 16'h0, 16'(rd_ready));
    @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("underrun after reset", 16'h0, 16'(underrun));
    chk("fifo ready after reset", 16'h1, 16'(rd_ready));
    $display("test underrun done");
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    arst_n = 1'b0;
    cfg = '{SETUP_PER_COMMAND, 5'h0b, 5'h00, 3'h0, 5'h0a, 1'b0, 1'b0};
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (40) @(posedge clk_sys);
    t_modes();
    t_mixed();
    t_pre();
    t_under();
    tally_and_finish();
  end
endmodule
`default_nettype wire
